// ---- bench/avalon_host.sv ----
`default_nettype none

module avalon_host (
	// Clock
	input wire logic clk,
	// Avalon-MM master
	output logic [mac_tx_stats_pkg::ADDR_W-1:0] address,
	output logic read,
	output logic write,
	output logic [mac_tx_stats_pkg::BE_W-1:0] byteenable,
	output logic [mac_tx_stats_pkg::DATA_W-1:0] writedata,
	input wire logic [mac_tx_stats_pkg::DATA_W-1:0] readdata,
	input wire logic waitrequest
);
	timeunit 1ns;
	timeprecision 1ns;
	import mac_tx_stats_pkg::*;

	// ------------------------------------------------------------
	// Host processor bus cycles
	// ------------------------------------------------------------
	initial begin
		address = '0;
		read = 1'b0;
		write = 1'b0;
		byteenable = 4'hF;
		writedata = '0;
	end

	// Request stands until waitrequest is sampled low
	task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
		@(posedge clk);
		address <= a;
		read <= !wr;
		write <= wr;
		writedata <= d;
		do @(posedge clk); while (waitrequest !== 1'b0);
		q = readdata;
		// Released lines show the inverse, so stale values cannot pass
		read <= 1'b0;
		write <= 1'b0;
		address <= ~a;
		writedata <= ~d;
	endtask : access
endmodule : avalon_host

`default_nettype wire

// ---- bench/mac_tx_stats_asserts.sv ----
`default_nettype none

module mac_tx_stats_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register bus
	input wire logic [mac_tx_stats_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [mac_tx_stats_pkg::BE_W-1:0] byteenable,
	input wire logic [mac_tx_stats_pkg::DATA_W-1:0] writedata,
	input wire logic [mac_tx_stats_pkg::DATA_W-1:0] readdata,
	input wire logic waitrequest,
	// Flags and interrupt
	input wire logic [mac_tx_stats_pkg::RX_STAT_W-1:0] rxHalfFull,
	input wire logic counterIrq
);
	import mac_tx_stats_pkg::*;

	// ------------------------------------------------------------
	// Shadow registers
	// ------------------------------------------------------------
	logic [DATA_W-1:0] txMask;
	logic [DATA_W-1:0] rxMask;
	logic clr;
	wire logic rdDone = read && !waitrequest;
	wire logic [DATA_W-1:0] lanes = {{8{byteenable[3]}}, {8{byteenable[2]}},
		{8{byteenable[1]}}, {8{byteenable[0]}}};
	wire logic [DATA_W-1:0] upd = writedata & lanes;

	// Shadows follow accepted writes lane by lane
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			txMask <= '0;
			rxMask <= '0;
			clr <= 1'b0;
		end else if (write && !waitrequest) begin
			if (address == OFF_TX_MASK)
				txMask <= (txMask & ~lanes | upd) & 32'h01FFFFFF;
			if (address == OFF_RX_MASK)
				rxMask <= (rxMask & ~lanes | upd) & 32'h00FFFFFF;
			if (address == OFF_CTRL && byteenable[0])
				clr <= writedata[CTRL_CLEAR_BIT];
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("request not answered after one wait cycle");
	chk_wait_pulse: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low for more than one cycle");
	chk_unmapped_zero: assert property (rdDone
		&& (address < OFF_CTRL || address > OFF_TX_BIN_511) |-> readdata == '0)
		else $error("unmapped read not zero");
	chk_status_resv: assert property (rdDone && address == OFF_TX_STATUS
		|-> readdata[31:8] == '0)
		else $error("tx status upper bits not zero");
	chk_txmask_read: assert property (rdDone && address == OFF_TX_MASK
		|-> readdata == txMask)
		else $error("tx mask readback wrong");
	chk_rxmask_read: assert property (rdDone && address == OFF_RX_MASK
		|-> readdata == rxMask)
		else $error("rx mask readback wrong");
	chk_clear_zero: assert property (rdDone && address >= OFF_TX_OCTET
		&& clr && $past(clr) && $past(clr, 2) |-> readdata == '0)
		else $error("counter not held at zero while cleared");
	chk_irq_rx: assert property (|(rxHalfFull & ~rxMask[RX_STAT_W-1:0]) |=> counterIrq)
		else $error("unmasked rx flag gave no interrupt");
	chk_reset_quiet: assert property ($rose(rst_n) |-> waitrequest && !counterIrq)
		else $error("outputs not quiet after reset");
endmodule : mac_tx_stats_asserts

bind mac_tx_statistics_counters mac_tx_stats_asserts u_asserts (.clk(clk), .rst_n(rst_n),
	.address(address), .read(read), .write(write), .byteenable(byteenable),
	.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
	.rxHalfFull(rxHalfFull), .counterIrq(counterIrq));

`default_nettype wire

// ---- bench/tb.sv ----
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import mac_tx_stats_pkg::*;

	// ------------------------------------------------------------
	// Bench state
	// ------------------------------------------------------------
	logic clk;
	logic rst_n;
	logic [ADDR_W-1:0] address;
	logic read;
	logic write;
	logic [BE_W-1:0] byteenable;
	logic [DATA_W-1:0] writedata;
	logic [DATA_W-1:0] readdata;
	logic waitrequest;
	tx_report_s txReport;
	logic [RX_STAT_W-1:0] rxHalfFull;
	logic counterIrq;
	logic [31:0] lfsr = 32'h19;
	logic stopRoll = 1'b0;
	logic clearAll = 1'b0;
	logic clearOnRead = 1'b0;
	logic [CNT_W-1:0] expCnt [TX_CNT_NUM];
	logic [DATA_W-1:0] q;
	logic [LEN_W-1:0] corner [9] = '{16'h0000, 16'h0040, 16'h0041, 16'h007F,
		16'h0080, 16'h00FF, 16'h0100, 16'h01FF, 16'h0200};
	int nErrors = 0;
	int comparisons = 0;
	int cycles = 0;

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	mac_tx_statistics_counters u_mac_tx_statistics_counters (.clk(clk), .rst_n(rst_n),
		.address(address), .read(read), .write(write), .byteenable(byteenable),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.txReport(txReport), .rxHalfFull(rxHalfFull), .counterIrq(counterIrq));

	avalon_host host (.clk(clk), .address(address), .read(read), .write(write),
		.byteenable(byteenable), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest));

	// Hang guard; a full run takes about 70k cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			nErrors++;
			endOfTest();
		end
	end

	function automatic logic [31:0] nextRand(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : nextRand

	// Saturates or wraps as the stop-rollover setting says
	function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] v,
		input logic [LEN_W-1:0] n);
		logic [CNT_W:0] s;
		s = {1'b0, v} + n;
		return (stopRoll && s[CNT_W]) ? 32'hFFFFFFFF : s[CNT_W-1:0];
	endfunction : bump

	function automatic int binOf(input logic [LEN_W-1:0] n);
		return n <= 16'h0040 ? IDX_BIN_64 : n <= 16'h007F ? IDX_BIN_127 :
			n <= 16'h00FF ? IDX_BIN_255 : IDX_BIN_511;
	endfunction : binOf

	task automatic check(input string what, input logic [DATA_W-1:0] seen,
		input logic [DATA_W-1:0] want);
		comparisons++;
		if (seen !== want) begin
			nErrors++;
			$display("wrong value %s expected %h seen %h", what, want, seen);
		end
	endtask : check

	task automatic rd(input logic [ADDR_W-1:0] a);
		host.access(1'b0, a, '0, q);
	endtask : rd

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		host.access(1'b1, a, d, q);
	endtask : wr

	// One report per cycle; the model counts it unless counters are held clear
	task automatic frame(input logic [LEN_W-1:0] n, input logic g, input logic b,
		input logic m);
		@(posedge clk);
		txReport <= {1'b1, g, b, m, n};
		if (!clearAll) begin
			expCnt[IDX_OCTET] = bump(expCnt[IDX_OCTET], n);
			expCnt[IDX_FRAME] = bump(expCnt[IDX_FRAME], 16'h1);
			if (g && b)
				expCnt[IDX_GOOD_BCAST] = bump(expCnt[IDX_GOOD_BCAST], 16'h1);
			if (g && m)
				expCnt[IDX_GOOD_MCAST] = bump(expCnt[IDX_GOOD_MCAST], 16'h1);
			if (n < 16'h0200)
				expCnt[binOf(n)] = bump(expCnt[binOf(n)], 16'h1);
		end
	endtask : frame

	task automatic idle();
		@(posedge clk);
		txReport <= {1'b0, lfsr[18:0]};
	endtask : idle

	task automatic setCtrl(input logic [CTRL_W-1:0] v);
		wr(OFF_CTRL, {29'h0, v});
		clearAll = v[0];
		stopRoll = v[1];
		clearOnRead = v[2];
		if (v[0])
			expCnt = '{default: '0};
	endtask : setCtrl

	task automatic checkCounters();
		for (int i = 0; i < TX_CNT_NUM; i++) begin
			rd(OFF_TX_OCTET + ADDR_W'(4 * i));
			check("counter", q, expCnt[i]);
			if (clearOnRead)
				expCnt[i] = '0;
		end
	endtask : checkCounters

	task automatic endOfTest();
		$display("comparisons %0d mismatches %0d", comparisons, nErrors);
		if (nErrors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : endOfTest

	initial begin
		rst_n = 1'b0;
		txReport = '0;
		rxHalfFull = '0;
		expCnt = '{default: '0};
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		for (int a = 32'h100; a <= 32'h134; a += 4) begin
			rd(ADDR_W'(a));
			check("reset value", q, 32'h0);
		end
		wr(OFF_TX_OCTET, lfsr);
		rd(OFF_TX_OCTET);
		check("read-only counter", q, 32'h0);
		$display("test reset done");
		foreach (corner[i]) frame(corner[i], 1'b1, i[0], i[1]);
		repeat (60) begin
			lfsr = nextRand(lfsr);
			frame({6'h0, lfsr[9:0]}, lfsr[10], lfsr[11], lfsr[12]);
		end
		idle();
		checkCounters();
		lfsr = nextRand(lfsr);
		wr(OFF_TX_MASK, lfsr);
		rd(OFF_TX_MASK);
		check("tx mask", q, lfsr & 32'h01FFFFFF);
		wr(OFF_RX_MASK, ~lfsr);
		wr(OFF_TX_MASK, 32'h0);
		wr(OFF_RX_MASK, 32'hFFFFFFFF);
		$display("test counting done");
		setCtrl(3'h4);
		frame(16'h0030, 1'b1, 1'b1, 1'b0);
		idle();
		checkCounters();
		checkCounters();
		// A frame counted at the edge that captures the read must survive the clear
		fork
			rd(OFF_TX_OCTET);
			begin
				frame(16'h0030, 1'b1, 1'b1, 1'b0);
				idle();
			end
		join
		check("octet read beside frame", q, 32'h0);
		checkCounters();
		setCtrl(3'h1);
		frame(16'h0100, 1'b1, 1'b0, 1'b1);
		idle();
		checkCounters();
		$display("test clearing done");
		setCtrl(3'h2);
		repeat (32769) frame(16'hFFFF, 1'b0, 1'b1, 1'b1);
		idle();
		rd(OFF_TX_STATUS);
		check("tx status", q, 32'h1);
		check("irq", {31'h0, counterIrq}, 32'h1);
		repeat (32769) frame(16'hFFFF, 1'b0, 1'b1, 1'b1);
		idle();
		checkCounters();
		setCtrl(3'h0);
		frame(16'h0001, 1'b0, 1'b0, 1'b0);
		idle();
		checkCounters();
		wr(OFF_TX_MASK, 32'h1);
		repeat (3) @(posedge clk);
		check("irq tx masked", {31'h0, counterIrq}, 32'h0);
		$display("test rollover done");
		lfsr = nextRand(lfsr);
		rxHalfFull <= lfsr[23:0] | 24'h1;
		repeat (3) @(posedge clk);
		check("irq rx masked", {31'h0, counterIrq}, 32'h0);
		rd(OFF_RX_STATUS);
		check("rx status", q, {8'h0, rxHalfFull});
		wr(OFF_RX_MASK, 32'hFFFFFE);
		repeat (3) @(posedge clk);
		check("irq rx open", {31'h0, counterIrq}, 32'h1);
		setCtrl(3'h1);
		rd(OFF_TX_STATUS);
		check("status cleared", q, 32'h0);
		$display("test interrupt done");
		endOfTest();
	end
endmodule : tb

`default_nettype wire

// ---- src/mac_tx_statistics_counters.sv ----
// Behaviour
// - Tx half-full flag sets at counter half scale
// - Tx status bits 24..0, upper bits zero
// - Rx mask bit zero lets rx flag interrupt
// - Tx mask bit zero lets tx flag interrupt
// - Tx mask mirrors status, resets to zero
// - Octet counter adds all frame bytes
// - Frame counter counts good and bad frames
// - Broadcast counter counts good broadcast only
// - Multicast counter counts good multicast only
// - Bin counts frames of 64 bytes or less
// - Bin counts frames of 65 to 127
// - Bin counts frames of 128 to 255
// - Bin counts frames of 256 to 511
// - Counters are 32 bits, LSB lowest address
// - Clear-on-read clears counter after LSB read
// - Stop-rollover saturates, otherwise counters wrap
// - Clear control clears all counters while set
//
// Design decision made here: the Avalon-MM slave port.

`default_nettype none

module mac_tx_statistics_counters (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Avalon-MM register slave
	input wire logic [mac_tx_stats_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [mac_tx_stats_pkg::BE_W-1:0] byteenable,
	input wire logic [mac_tx_stats_pkg::DATA_W-1:0] writedata,
	output logic [mac_tx_stats_pkg::DATA_W-1:0] readdata,
	output logic waitrequest,
	// Frame reports from the MAC transmit path
	input wire mac_tx_stats_pkg::tx_report_s txReport,
	// Half-full flags from the receive counters
	input wire logic [mac_tx_stats_pkg::RX_STAT_W-1:0] rxHalfFull,
	// Counter interrupt
	output logic counterIrq
);
	import mac_tx_stats_pkg::*;

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------

	// Add with optional saturation at full scale
	function automatic logic [CNT_W-1:0] bumpCount(
		input logic [CNT_W-1:0] value,
		input logic [CNT_W-1:0] amount,
		input logic stopRoll
	);
		logic [CNT_W:0] sum;
		sum = {1'b0, value} + {1'b0, amount};
		if (sum[CNT_W] && stopRoll) begin
			bumpCount = CNT_MAX;
		end else begin
			bumpCount = sum[CNT_W-1:0];
		end
	endfunction : bumpCount

	// Byte-lane merge for writable registers
	function automatic logic [DATA_W-1:0] mergeBytes(
		input logic [DATA_W-1:0] oldValue,
		input logic [DATA_W-1:0] newValue,
		input logic [BE_W-1:0] lanes
	);
		logic [DATA_W-1:0] merged;
		merged = oldValue;
		for (int b = 0; b < BE_W; b++) begin
			if (lanes[b]) begin
				merged[b*8 +: 8] = newValue[b*8 +: 8];
			end
		end
		mergeBytes = merged;
	endfunction : mergeBytes

	// Byte offset of a counter word from its index
	function automatic logic [ADDR_W-1:0] counterOffset(input int idx);
		counterOffset = OFF_TX_OCTET + ADDR_W'(idx * BE_W);
	endfunction : counterOffset

	// 16-bit length widened to counter width
	function automatic logic [CNT_W-1:0] widen(input logic [LEN_W-1:0] value);
		widen = {{(CNT_W-LEN_W){1'b0}}, value};
	endfunction : widen

	// Length above one bin bound and up to the next
	function automatic logic inRange(input logic [LEN_W-1:0] value,
		input logic [LEN_W-1:0] low, input logic [LEN_W-1:0] high);
		inRange = (value > low) && (value <= high);
	endfunction : inRange

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	bus_state_e busState;
	logic [CTRL_W-1:0] control;
	logic [TX_STAT_W-1:0] txMask;
	logic [RX_STAT_W-1:0] rxMask;
	logic [TX_CNT_NUM-1:0] txHalf;
	logic [CNT_W-1:0] counts [TX_CNT_NUM];
	logic [CNT_W-1:0] next_counts [TX_CNT_NUM];
	logic [CNT_W-1:0] incAmount [TX_CNT_NUM];
	logic [TX_CNT_NUM-1:0] readClear;
	logic [TX_STAT_W-1:0] txStatus;
	logic [DATA_W-1:0] next_readData;
	logic accept;
	logic acceptWrite;
	logic captureRead;
	logic [TX_CNT_NUM-1:0] counterSel;
	logic clearAll;
	logic stopRoll;
	logic clearOnRead;

	// Request is taken at the edge where waitrequest is seen low
	assign accept = (busState == BUS_ACK) && (read || write);
	assign acceptWrite = accept && write;
	// Reads are captured one edge earlier, when the request is first seen;
	// a clear-on-read at that edge keeps the frame counted there
	assign captureRead = (busState == BUS_IDLE) && read;

	// Control fields
	assign clearAll = control[CTRL_CLEAR_BIT];
	assign stopRoll = control[CTRL_STOP_ROLL_BIT];
	assign clearOnRead = control[CTRL_CLEAR_ON_READ_BIT];

	// ------------------------------------------------------------
	// Avalon handshake: one wait cycle, then acknowledge
	// ------------------------------------------------------------

	// Bus state; ACK lasts one cycle, so back-to-back requests each wait once
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busState <= BUS_IDLE;
		end else begin
			case (busState)
				BUS_IDLE: begin
					if (read || write) begin
						busState <= BUS_ACK;
					end
				end
				BUS_ACK: busState <= BUS_IDLE;
				default: busState <= BUS_IDLE;
			endcase
		end
	end

	// Waitrequest low exactly during the ACK cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			waitrequest <= 1'b1;
		end else begin
			waitrequest <= !((busState == BUS_IDLE) && (read || write));
		end
	end

	// ------------------------------------------------------------
	// Control and mask registers
	// ------------------------------------------------------------

	// clear control is a level held by software
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			control <= CTRL_RESET;
		end else if (acceptWrite && address == OFF_CTRL && byteenable[0]) begin
			control <= writedata[CTRL_W-1:0];
		end
	end

	// tx mask resets to all unmasked
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			txMask <= TX_MASK_RESET;
		end else if (acceptWrite && address == OFF_TX_MASK) begin
			txMask <= TX_STAT_W'(mergeBytes(DATA_W'(txMask), writedata, byteenable));
		end
	end

	// Rx mask, same layout as rx status
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rxMask <= RX_MASK_RESET;
		end else if (acceptWrite && address == OFF_RX_MASK) begin
			rxMask <= RX_STAT_W'(mergeBytes(DATA_W'(rxMask), writedata, byteenable));
		end
	end

	// ------------------------------------------------------------
	// Per-frame increments
	// ------------------------------------------------------------

	// Amount each counter gains from this cycle's report
	always_comb begin
		for (int i = 0; i < TX_CNT_NUM; i++) begin
			incAmount[i] = CNT_ZERO;
		end
		if (txReport.valid) begin
			// length excludes preamble; retries reported once
			incAmount[IDX_OCTET] = widen(txReport.length);
			incAmount[IDX_FRAME] = CNT_W'(1);
			incAmount[IDX_GOOD_BCAST] = CNT_W'(txReport.good && txReport.broadcast);
			incAmount[IDX_GOOD_MCAST] = CNT_W'(txReport.good && txReport.multicast);
			incAmount[IDX_BIN_64] = CNT_W'(txReport.length <= BIN_64_MAX);
			incAmount[IDX_BIN_127] = CNT_W'(inRange(txReport.length, BIN_64_MAX, BIN_127_MAX));
			incAmount[IDX_BIN_255] = CNT_W'(inRange(txReport.length, BIN_127_MAX, BIN_255_MAX));
			incAmount[IDX_BIN_511] = CNT_W'(inRange(txReport.length, BIN_255_MAX, BIN_511_MAX));
		end
	end

	// ------------------------------------------------------------
	// Counters
	// ------------------------------------------------------------

	// One-hot counter select, shared by the clear and the read mux
	// Unaligned byte addresses select nothing
	always_comb begin
		for (int i = 0; i < TX_CNT_NUM; i++) begin
			counterSel[i] = (address == counterOffset(i));
		end
	end

	// A read that delivers the low byte lane clears the counter
	always_comb begin
		for (int i = 0; i < TX_CNT_NUM; i++) begin
			// clear as the least significant byte is captured
			readClear[i] = clearOnRead && captureRead && byteenable[0] && counterSel[i];
		end
	end

	// Next counter values; a frame seen during a read-clear is kept
	// Clear-all wins over read-clear, which drops the old count but keeps this cycle's increment
	always_comb begin
		for (int i = 0; i < TX_CNT_NUM; i++) begin
			if (clearAll) begin
				next_counts[i] = CNT_ZERO;
			end else if (readClear[i]) begin
				next_counts[i] = incAmount[i];
			end else begin
				next_counts[i] = bumpCount(counts[i], incAmount[i], stopRoll);
			end
		end
	end

	// Counter storage; reset to zero although software sees no default
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < TX_CNT_NUM; i++) begin
				counts[i] <= CNT_ZERO;
			end
		end else begin
			for (int i = 0; i < TX_CNT_NUM; i++) begin
				counts[i] <= next_counts[i];
			end
		end
	end

	// ------------------------------------------------------------
	// Half-full flags
	// ------------------------------------------------------------

	// Sticky until the counter itself is cleared; clear beats set, since a cleared count never has HALF_BIT set
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			txHalf <= '0;
		end else begin
			for (int i = 0; i < TX_CNT_NUM; i++) begin
				// set on reaching half of full scale
				if (clearAll || readClear[i]) begin
					txHalf[i] <= next_counts[i][HALF_BIT];
				end else begin
					txHalf[i] <= txHalf[i] | next_counts[i][HALF_BIT];
				end
			end
		end
	end

	// counters kept elsewhere, and the VLAN bit, read zero here
	assign txStatus = {{(TX_STAT_W-TX_CNT_NUM){1'b0}}, txHalf};

	// ------------------------------------------------------------
	// Interrupt
	// ------------------------------------------------------------

	// Registered so the pin comes from a flop; one cycle behind the flags
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			counterIrq <= 1'b0;
		end else begin
			// mask bit zero lets the flag through
			counterIrq <= (|(txStatus & ~txMask)) || (|(rxHalfFull & ~rxMask));
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------

	// Read mux; unmapped offsets answer zero
	always_comb begin
		next_readData = '0;
		case (address)
			OFF_CTRL: next_readData = DATA_W'(control);
			OFF_RX_STATUS: next_readData = DATA_W'(rxHalfFull);
			OFF_TX_STATUS: next_readData = DATA_W'(txStatus);
			OFF_RX_MASK: next_readData = DATA_W'(rxMask);
			OFF_TX_MASK: next_readData = DATA_W'(txMask);
			default: begin
				for (int i = 0; i < TX_CNT_NUM; i++) begin
					if (counterSel[i]) begin
						// full 32-bit word, LSB in lane 0
						next_readData = counts[i];
					end
				end
			end
		endcase
	end

	// Captured on entry to ACK so it stands at the accepting edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			readdata <= '0;
		end else if (captureRead) begin
			readdata <= next_readData;
		end
	end

endmodule : mac_tx_statistics_counters

`default_nettype wire

// ---- src/mac_tx_stats_pkg.sv ----
`default_nettype none

package mac_tx_stats_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int ADDR_W = 9;
	localparam int DATA_W = 32;
	localparam int BE_W = 4;
	localparam int CNT_W = 32;
	localparam int LEN_W = 16;
	localparam int TX_CNT_NUM = 8;
	localparam int TX_STAT_W = 25;
	localparam int RX_STAT_W = 24;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_CTRL = 9'h100;
	localparam logic [ADDR_W-1:0] OFF_RX_STATUS = 9'h104;
	localparam logic [ADDR_W-1:0] OFF_TX_STATUS = 9'h108;
	localparam logic [ADDR_W-1:0] OFF_RX_MASK = 9'h10C;
	localparam logic [ADDR_W-1:0] OFF_TX_MASK = 9'h110;
	localparam logic [ADDR_W-1:0] OFF_TX_OCTET = 9'h114;
	localparam logic [ADDR_W-1:0] OFF_TX_FRAME = 9'h118;
	localparam logic [ADDR_W-1:0] OFF_TX_GOOD_BCAST = 9'h11C;
	localparam logic [ADDR_W-1:0] OFF_TX_GOOD_MCAST = 9'h120;
	localparam logic [ADDR_W-1:0] OFF_TX_BIN_64 = 9'h124;
	localparam logic [ADDR_W-1:0] OFF_TX_BIN_127 = 9'h128;
	localparam logic [ADDR_W-1:0] OFF_TX_BIN_255 = 9'h12C;
	localparam logic [ADDR_W-1:0] OFF_TX_BIN_511 = 9'h130;

	// ------------------------------------------------------------
	// Control fields and reset values
	// ------------------------------------------------------------
	localparam int CTRL_W = 3;
	localparam int CTRL_CLEAR_BIT = 0;
	localparam int CTRL_STOP_ROLL_BIT = 1;
	localparam int CTRL_CLEAR_ON_READ_BIT = 2;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
	localparam logic [TX_STAT_W-1:0] TX_MASK_RESET = 25'h0;
	localparam logic [RX_STAT_W-1:0] RX_MASK_RESET = 24'h0;
	localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0;
	localparam logic [CNT_W-1:0] CNT_MAX = 32'hFFFFFFFF;
	localparam int HALF_BIT = 31;

	// ------------------------------------------------------------
	// Counter indices, equal to their status bit positions
	// ------------------------------------------------------------
	localparam int IDX_OCTET = 0;
	localparam int IDX_FRAME = 1;
	localparam int IDX_GOOD_BCAST = 2;
	localparam int IDX_GOOD_MCAST = 3;
	localparam int IDX_BIN_64 = 4;
	localparam int IDX_BIN_127 = 5;
	localparam int IDX_BIN_255 = 6;
	localparam int IDX_BIN_511 = 7;
	localparam int STAT_VLAN_BIT = 24;

	// ------------------------------------------------------------
	// Size bin upper bounds in bytes
	// ------------------------------------------------------------
	localparam logic [LEN_W-1:0] BIN_64_MAX = 16'h0040;
	localparam logic [LEN_W-1:0] BIN_127_MAX = 16'h007F;
	localparam logic [LEN_W-1:0] BIN_255_MAX = 16'h00FF;
	localparam logic [LEN_W-1:0] BIN_511_MAX = 16'h01FF;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACK = 1'b1
	} bus_state_e;

	// One report per finished transmit frame, length without preamble
	typedef struct packed {
		logic valid;
		logic good;
		logic broadcast;
		logic multicast;
		logic [LEN_W-1:0] length;
	} tx_report_s;

endpackage : mac_tx_stats_pkg

`default_nettype wire
